// file: hw/hpvc_top.sv
// headphone volume and analog path control register bank
// Contract
// - each headphone channel holds a 7-bit log gain, 1 dB steps, +6 to -73 dB.
// - gain codes below 0110000 mute the channel.
// - both gains reset to 1111001 (0 dB), in bits 6:0.
// - left and right have separate registers and change independently.
// - with zero-cross on, new gain applies only when input is near ground.
// - gated update never times out; steady dc keeps it pending.
// - bit 7 of the volume write enables zero-cross; default off.
// - a write with zero-cross off applies at once; host may resend to unblock.
// - bit 8 in a left write also loads gain and enable into right.
// - bit 8 in a right write also loads gain and enable into left.
// - bypass is path bit 3, routes line inputs out, resets to 1.
// - volume controls and mutes still act on the bypass signal.
// - sidetone is path bit 5, routes microphone out, resets to 0.
// - bits 7:6 pick sidetone attenuation -6/-9/-12/-15 dB, reset 00.
// - mic boost and phone volume stay effective; host deselects others.
`timescale 1ns/1ps
module hpvc_top (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       wr_strobe,
   input  wire logic [6:0] wr_addr,
   input  wire logic [8:0] wr_data,
   input  wire logic [6:0] rd_addr,
   output logic [8:0]      rd_data,
   input  wire logic       left_near_ground,
   input  wire logic       right_near_ground,
   output logic [6:0]      left_phones_gain,
   output logic [6:0]      right_phones_gain,
   output logic            left_phones_mute,
   output logic            right_phones_mute,
   output logic            left_gain_pending,
   output logic            right_gain_pending,
   output logic            bypass_enable,
   output logic            sidetone_enable,
   output logic [1:0]      mic_monitor_atten,
   output logic            converter_to_line_select,
   output logic            mic_input_select
);
   // index 0 is the left channel, index 1 the right
   hpvc_chan_if chan_req [2] ();

   wire       wr_left;
   wire       wr_right;
   wire       wr_path;
   wire [6:0] data_gain;
   wire       data_zc;
   wire       data_copy;
   wire [1:0] chan_load;
   wire [1:0] chan_near_ground;
   wire [6:0] chan_written [2];
   wire [1:0] chan_zc;
   wire [6:0] chan_applied [2];
   wire [1:0] chan_mute;
   wire [1:0] chan_pend;

   // the serial control front end hands over whole words
   assign wr_left   = wr_strobe && (wr_addr == hpvc_pkg::ADDR_LEFT_PHONES);
   assign wr_right  = wr_strobe && (wr_addr == hpvc_pkg::ADDR_RIGHT_PHONES);
   assign wr_path   = wr_strobe && (wr_addr == hpvc_pkg::ADDR_ANALOG_PATH);
   assign data_gain = wr_data[hpvc_pkg::GAIN_MSB:hpvc_pkg::GAIN_LSB];
   assign data_zc   = wr_data[hpvc_pkg::ZC_ENABLE_BIT];
   assign data_copy = wr_data[hpvc_pkg::COPY_BIT];

   // both writes never arrive together, so one source word feeds both loads
   assign chan_load[0]     = wr_left || (wr_right && data_copy);
   assign chan_load[1]     = wr_right || (wr_left && data_copy);
   assign chan_near_ground = {right_near_ground, left_near_ground};

   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      assign chan_req[ch].load      = chan_load[ch];
      assign chan_req[ch].gain      = data_gain;
      assign chan_req[ch].zc_enable = data_zc;

      hpvc_channel hpvc_channel_i (
         .mclk         (mclk),
         .rst          (rst),
         .req          (chan_req[ch]),
         .near_ground  (chan_near_ground[ch]),
         .written_gain (chan_written[ch]),
         .zc_enable    (chan_zc[ch]),
         .applied_gain (chan_applied[ch]),
         .muted        (chan_mute[ch]),
         .pending      (chan_pend[ch])
      );
   end

   // analog path register; bit 8 and bits 2..0 other than input select unused
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bypass_enable            <= hpvc_pkg::BYPASS_RESET;
         sidetone_enable          <= hpvc_pkg::SIDETONE_RESET;
         mic_monitor_atten        <= hpvc_pkg::ATTEN_RESET;
         converter_to_line_select <= hpvc_pkg::DAC_SEL_RESET;
         mic_input_select         <= hpvc_pkg::MIC_SEL_RESET;
      end else if (wr_path) begin
         bypass_enable            <= wr_data[hpvc_pkg::BYPASS_BIT];
         sidetone_enable          <= wr_data[hpvc_pkg::SIDETONE_BIT];
         mic_monitor_atten        <= wr_data[hpvc_pkg::ATTEN_MSB:hpvc_pkg::ATTEN_LSB];
         converter_to_line_select <= wr_data[hpvc_pkg::DAC_SELECT_BIT];
         mic_input_select         <= wr_data[hpvc_pkg::MIC_SELECT_BIT];
      end
   end

   // gain outputs stay live whatever the routing, so volume governs bypass
   // and sidetone signals too
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         left_phones_gain   <= hpvc_pkg::GAIN_RESET;
         right_phones_gain  <= hpvc_pkg::GAIN_RESET;
         left_phones_mute   <= 1'h0;
         right_phones_mute  <= 1'h0;
         left_gain_pending  <= 1'h0;
         right_gain_pending <= 1'h0;
      end else begin
         left_phones_gain   <= chan_applied[0];
         right_phones_gain  <= chan_applied[1];
         left_phones_mute   <= chan_mute[0];
         right_phones_mute  <= chan_mute[1];
         left_gain_pending  <= chan_pend[0];
         right_gain_pending <= chan_pend[1];
      end
   end

   // readback shows the written settings; copy bits are write-only actions
   logic [8:0] next_rd_data;
   always_comb begin
      case (rd_addr)
         hpvc_pkg::ADDR_LEFT_PHONES:  next_rd_data = {1'h0, chan_zc[0], chan_written[0]};
         hpvc_pkg::ADDR_RIGHT_PHONES: next_rd_data = {1'h0, chan_zc[1], chan_written[1]};
         hpvc_pkg::ADDR_ANALOG_PATH:  next_rd_data = {1'h0, mic_monitor_atten,
                                                      sidetone_enable,
                                                      converter_to_line_select,
                                                      bypass_enable,
                                                      mic_input_select, 2'h0};
         default:                     next_rd_data = 9'h000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data <= 9'h000;
      end else begin
         rd_data <= next_rd_data;
      end
   end
endmodule

// file: hw/hpvc_pkg.sv
// constants and types for the headphone volume and analog path control block
package hpvc_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 9;
   localparam int GAIN_W = 7;
   localparam logic [6:0] ADDR_LEFT_PHONES  = 7'h02;
   localparam logic [6:0] ADDR_RIGHT_PHONES = 7'h03;
   localparam logic [6:0] ADDR_ANALOG_PATH  = 7'h04;
   localparam int GAIN_LSB        = 0;
   localparam int GAIN_MSB        = 6;
   localparam int ZC_ENABLE_BIT   = 7;
   localparam int COPY_BIT        = 8;
   localparam int MIC_SELECT_BIT  = 2;
   localparam int BYPASS_BIT      = 3;
   localparam int DAC_SELECT_BIT  = 4;
   localparam int SIDETONE_BIT    = 5;
   localparam int ATTEN_LSB       = 6;
   localparam int ATTEN_MSB       = 7;
   localparam logic [6:0] GAIN_RESET     = 7'h79;
   localparam logic [6:0] GAIN_MUTE_BELOW = 7'h30;
   localparam logic       ZC_RESET       = 1'h0;
   localparam logic       BYPASS_RESET   = 1'h1;
   localparam logic       SIDETONE_RESET = 1'h0;
   localparam logic [1:0] ATTEN_RESET    = 2'h0;
   localparam logic       MIC_SEL_RESET  = 1'h0;
   localparam logic       DAC_SEL_RESET  = 1'h0;
   localparam logic [8:0] PATH_SPARE_RESET = 9'h000;
endpackage

// file: hw/hpvc_chan_if.sv
// per-channel load request from the register decoder to a gain channel
`timescale 1ns/1ps
interface hpvc_chan_if;
   logic       load;
   logic [6:0] gain;
   logic       zc_enable;
   modport src (output load, output gain, output zc_enable);
   modport dst (input load, input gain, input zc_enable);
endinterface

// file: hw/hpvc_channel.sv
// one headphone channel: written settings, pending gain and applied gain
`timescale 1ns/1ps
module hpvc_channel (
   input  wire logic  mclk,
   input  wire logic  rst,
   hpvc_chan_if.dst   req,
   input  wire logic  near_ground,
   output logic [6:0] written_gain,
   output logic       zc_enable,
   output logic [6:0] applied_gain,
   output logic       muted,
   output logic       pending
);
   wire apply_now;
   wire apply_held;
   // gating is decided by the enable carried in this very write
   assign apply_now  = req.load && !req.zc_enable;
   // no timeout: a held gain waits for the analog stage as long as it takes
   assign apply_held = pending && near_ground && !req.load;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         written_gain <= hpvc_pkg::GAIN_RESET;
         zc_enable    <= hpvc_pkg::ZC_RESET;
         applied_gain <= hpvc_pkg::GAIN_RESET;
         pending      <= 1'h0;
      end else begin
         if (req.load) begin
            written_gain <= req.gain;
            zc_enable    <= req.zc_enable;
         end
         if (apply_now) begin
            applied_gain <= req.gain;
            pending      <= 1'h0;
         end else if (req.load) begin
            pending      <= 1'h1;
         end else if (apply_held) begin
            applied_gain <= written_gain;
            pending      <= 1'h0;
         end
      end
   end

   // low codes mute instead of setting a gain
   assign muted = applied_gain < hpvc_pkg::GAIN_MUTE_BELOW;
endmodule

// file: tb/hpvc_sva.sv
// concurrent checks on the headphone volume control ports
`timescale 1ns/1ps
module hpvc_sva (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       wr_strobe,
   input wire logic [6:0] wr_addr,
   input wire logic [8:0] wr_data,
   input wire logic       left_near_ground,
   input wire logic [6:0] left_phones_gain,
   input wire logic [6:0] right_phones_gain,
   input wire logic       left_phones_mute,
   input wire logic       left_gain_pending,
   input wire logic       bypass_enable,
   input wire logic       sidetone_enable,
   input wire logic [1:0] mic_monitor_atten
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire lw = wr_strobe && wr_addr == 7'h02;
   wire rw = wr_strobe && wr_addr == 7'h03;
   a_mute_decode: assert property (left_phones_mute == (left_phones_gain < 7'h30))
      else $error("mute flag wrong");
   a_direct_apply: assert property (lw && !wr_data[7] ##1 !wr_strobe |=>
      left_phones_gain == $past(wr_data[6:0], 2)) else $error("direct gain wrong");
   a_copy_right: assert property (lw && wr_data[8:7] == 2'h2 ##1 !wr_strobe |=>
      right_phones_gain == $past(wr_data[6:0], 2)) else $error("copy to right wrong");
   a_copy_left: assert property (rw && wr_data[8:7] == 2'h2 ##1 !wr_strobe |=>
      left_phones_gain == $past(wr_data[6:0], 2)) else $error("copy to left wrong");
   a_gated_pend: assert property (lw && wr_data[8:7] == 2'h1 ##1
      !wr_strobe && !left_near_ground |=> left_gain_pending) else $error("not pending");
   // gain may only move two edges after a write or a near-ground indication
   a_gated_hold: assert property (!$past(left_near_ground, 2) &&
      !$past(wr_strobe, 2) |-> $stable(left_phones_gain)) else $error("gain moved");
   a_ground_apply: assert property (left_near_ground && !wr_strobe |->
      ##2 !left_gain_pending) else $error("pending not cleared");
   a_path_sets: assert property (wr_strobe && wr_addr == 7'h04 |=>
      {mic_monitor_atten, sidetone_enable, bypass_enable} == {$past(wr_data[7:6]),
      $past(wr_data[5]), $past(wr_data[3])}) else $error("path bits wrong");
   cover property (left_gain_pending && left_near_ground);
   cover property (rw && wr_data[8]);
   cover property (sidetone_enable && mic_monitor_atten == 2'h3);
endmodule
bind hpvc_top hpvc_sva hpvc_sva_i (.*);

// file: tb/hpvc_host.sv
// host-side model issuing register writes as the serial front end would
`timescale 1ns/1ps
module hpvc_host (
   input  wire logic       mclk,
   output logic            wr_strobe,
   output logic [6:0]      wr_addr,
   output logic [8:0]      wr_data
);
   initial begin
      wr_strobe = 1'h0;
      wr_addr   = 7'h7F;
      wr_data   = 9'h1FF;
   end
   // released address and data are inverted so stale values never look valid
   task automatic send(input logic [6:0] a, input logic [8:0] d);
      @(negedge mclk);
      wr_strobe <= 1'h1;
      wr_addr   <= a;
      wr_data   <= d;
      @(negedge mclk);
      wr_strobe <= 1'h0;
      wr_addr   <= ~a;
      wr_data   <= ~d;
   endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the headphone volume and path control block
`timescale 1ns/1ps
module testbench;
   logic        mclk, rst, wr_strobe, left_near_ground, right_near_ground;
   logic        left_phones_mute, right_phones_mute, left_gain_pending, right_gain_pending;
   logic        bypass_enable, sidetone_enable, converter_to_line_select, mic_input_select;
   logic [1:0]  mic_monitor_atten;
   logic [6:0]  wr_addr, rd_addr, left_phones_gain, right_phones_gain, el, er, a;
   logic [8:0]  wr_data, rd_data, d;
   logic [31:0] seed;
   logic [8:0]  corner [4] = '{9'h02F, 9'h030, 9'h17F, 9'h100};
   int          num_errors = 0;
   int          compares = 0;
   hpvc_top  hpvc_top_i (.*);
   hpvc_host hpvc_host_i (.*);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [8:0] chan(input logic [6:0] g);
      return {1'h0, g < 7'h30, g};
   endfunction
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic vols();
      chk({1'h0, left_phones_mute, left_phones_gain}, chan(el));
      chk({1'h0, right_phones_mute, right_phones_gain}, chan(er));
   endtask
   task automatic rd(input logic [6:0] ra, input logic [8:0] exp);
      rd_addr = ra;
      cyc(2);
      chk(rd_data, exp);
   endtask
   task automatic path(input logic [8:0] exp);
      chk({3'h0, mic_monitor_atten, sidetone_enable, converter_to_line_select,
           bypass_enable, mic_input_select}, {3'h0, exp[7:2]});
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      #(8 * 3000);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      {rst, left_near_ground, right_near_ground, rd_addr} = {3'h4, 7'h00};
      {seed, el, er} = {32'h73B3B19A, 7'h79, 7'h79};
      cyc(20);
      rst = 1'h0;
      vols();
      rd(7'h02, 9'h079);
      rd(7'h04, 9'h008);
      rd(7'h06, 9'h000);
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         {left_near_ground, right_near_ground} = seed[11:10];
         d = (i < 4) ? corner[i] : {seed[8], 1'h0, seed[6:0]};
         // corners alternate left and right so both copy directions are hit
         a = 7'h02 + {6'h00, (i < 4) ? i[0] : seed[9]};
         hpvc_host_i.send(a, d);
         if (a == 7'h02 || d[8]) el = d[6:0];
         if (a == 7'h03 || d[8]) er = d[6:0];
         cyc(3);
         vols();
      end
      {left_near_ground, right_near_ground} = 2'h0;
      hpvc_host_i.send(7'h02, 9'h0A0);
      cyc(10);
      vols();
      chk({7'h00, left_gain_pending, right_gain_pending}, 9'h002);
      hpvc_host_i.send(7'h02, 9'h0A5);
      rd(7'h02, 9'h0A5);
      left_near_ground = 1'h1;
      cyc(1);
      left_near_ground = 1'h0;
      el = 7'h25;
      cyc(3);
      vols();
      hpvc_host_i.send(7'h03, 9'h0C0);
      hpvc_host_i.send(7'h03, 9'h040);
      er = 7'h40;
      cyc(3);
      vols();
      chk({7'h00, left_gain_pending, right_gain_pending}, 9'h000);
      for (int c = 0; c < 4; c++) begin
         d = {1'h0, 2'(c), 6'h27};
         hpvc_host_i.send(7'h04, d);
         cyc(2);
         path(d);
         rd(7'h04, d & 9'h0FC);
      end
      hpvc_host_i.send(7'h04, 9'h008);
      hpvc_host_i.send(7'h05, 9'h1FF);
      cyc(2);
      path(9'h008);
      vols();
      tally_and_finish();
   end
endmodule
